//--- rcp_defines.svh
// register map, field positions and reset values of the reset/clock block
`ifndef RCP_DEFINES_SVH
`define RCP_DEFINES_SVH

// ------------------------------
// byte addresses
// ------------------------------
`define RCP_CLOCK_CONFIG_ADDR   20'h50040
`define RCP_CONTROL_ADDR        20'h50044
`define RCP_PLL_ADDR            20'h50048
`define RCP_STATUS_WORD_ADDR    20'h5004c
`define RCP_REVISION_ADDR       20'h50090

// ------------------------------
// clock_config fields
// ------------------------------
`define RCP_CC_BUS_DIV_HI       13
`define RCP_CC_BUS_DIV_LO       12
`define RCP_CC_BUS_GATE         4
`define RCP_CC_USB_GATE         3
`define RCP_CC_CPU_SEL_HI       2
`define RCP_CC_CPU_SEL_LO       0
`define RCP_CC_MASK             32'h0000301f
`define RCP_CC_RESET            32'h00000000
`define RCP_CPU_SEL_117         3'h5
`define RCP_CPU_SEL_OSC         3'h6
`define RCP_BUS_DIV_ONE         2'h0

// ------------------------------
// reset_powerdown_control fields
// ------------------------------
`define RCP_RC_GLBL_CLK_SRC     20
`define RCP_RC_USB_PLL_PD       19
`define RCP_RC_MAIN_PLL_PD      18
`define RCP_RC_REFCLK_GATE      17
`define RCP_RC_MAC_PASS         14
`define RCP_RC_PHY_RST_SEL      13
`define RCP_RC_PHY_RST_SW       12
`define RCP_RC_PHY_SUSP_FORCE   11
`define RCP_RC_BB_WARM          10
`define RCP_RC_BB_COLD          9
`define RCP_RC_CG_COLD          8
`define RCP_RC_RADIO_WARM       7
`define RCP_RC_RADIO_COLD       6
`define RCP_RC_RF_RESET         5
`define RCP_RC_BUS_MSK          4
`define RCP_RC_CPU_MSK          3
`define RCP_RC_DMA_MSK          2
`define RCP_RC_WLAN_MSK         1
`define RCP_RC_GLOBAL           0
`define RCP_RC_MASK             32'h001e7fff
`define RCP_RC_RESET            32'h00000020

// ----------------------------------------------------------------------
// usb_pll_parameters and status word
// ----------------------------------------------------------------------
`define RCP_PLL_MASK            32'hffffffff
`define RCP_PLL_RESET           32'h6e1501e5
`define RCP_STATUS_RESET        32'h00000000
`define RCP_STATUS_MASK         32'hffffffff

`endif

//--- rcp_pkg.sv
// types shared by the reset, clock and power-down control block
package rcp_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;
endpackage

//--- reset_clock_power_control.sv
// reset, clock and power-down control with an AXI4-Lite register slave
// What this block does
// - bus clock gate bit 4: 0 free running, 1 gated.
// - usb controller clock gate bit 3: 0 running, 1 gated.
// - cpu clock select bits 2:0 pick 22, 88, 44, 117 MHz or 40 MHz osc.
// - bus clock is cpu clock over ratio, except 117 MHz and osc: ratio one.
// - bus divide bits 13:12: 00 one, 01 half, 10 quarter.
// - bit 20 low holds radio clock enable high, high lets mac drive it.
// - bit 19 low lets usb suspend power down usb pll, high forces it.
// - bit 18 low lets usb suspend power down main pll, high forces it.
// - bit 17 low lets usb suspend gate 40 MHz clock, high forces gating.
// - bit 14 low blocks mac reset controls, high passes them through.
// - phy reset from usb controller if bit 13, else software bit 12.
// - bit 11 low lets controller drive phy suspend, high forces it low.
// - bits 10 and 9 drive baseband warm and cold reset, one asserts.
// - bit 8 drives clock generation cold reset, one asserts.
// - bits 7 and 6 drive radio warm and cold reset, one asserts.
// - bit 5 drives rf reset, resets to one so rf reset starts asserted.
// - bit 0 resets bus, core, host dma, wireless where mask bits are set.
// - pll parameter register holds static settings driven to usb pll.
// - 32-bit read/write status word, cleared by reset.
// - read-only revision: major 7:4, minor 3:0, zero above.
// - reserved bits read as zero, writes to them are dropped.
`timescale 1ns/100ps
`include "rcp_defines.svh"

module reset_clock_power_control
  import rcp_pkg::*;
#(
  // arbitrary neutral revision code
  parameter logic [3:0] REV_MAJOR = 4'h1,
  // arbitrary neutral revision code
  parameter logic [3:0] REV_MINOR = 4'h0
) (
  input  wire  logic        CLK,
  input  wire  logic        NRST,
  input  wire  logic [19:0] S_AXI_AWADDR,
  input  wire  logic [2:0]  S_AXI_AWPROT,
  input  wire  logic        S_AXI_AWVALID,
  output logic              S_AXI_AWREADY,
  input  wire  logic [31:0] S_AXI_WDATA,
  input  wire  logic [3:0]  S_AXI_WSTRB,
  input  wire  logic        S_AXI_WVALID,
  output logic              S_AXI_WREADY,
  output logic [1:0]        S_AXI_BRESP,
  output logic              S_AXI_BVALID,
  input  wire  logic        S_AXI_BREADY,
  input  wire  logic [19:0] S_AXI_ARADDR,
  input  wire  logic [2:0]  S_AXI_ARPROT,
  input  wire  logic        S_AXI_ARVALID,
  output logic              S_AXI_ARREADY,
  output logic [31:0]       S_AXI_RDATA,
  output logic [1:0]        S_AXI_RRESP,
  output logic              S_AXI_RVALID,
  input  wire  logic        S_AXI_RREADY,
  input  wire  logic        USB_SUSPEND_REQ,
  input  wire  logic        USB_CTRL_PHY_RESET,
  input  wire  logic        USB_CTRL_PHY_SUSPEND_N,
  input  wire  logic        MAC_GLOBAL_CLK_EN,
  input  wire  logic        MAC_BB_WARM_RESET,
  input  wire  logic        MAC_BB_COLD_RESET,
  input  wire  logic        MAC_RADIO_WARM_RESET,
  input  wire  logic        MAC_RADIO_COLD_RESET,
  output logic              BUS_CLK_GATE,
  output logic              USB_CTRL_CLOCK_GATE,
  output logic [2:0]        CPU_CLK_SEL,
  output logic [1:0]        BUS_CLK_DIV,
  output logic              RADIO_GLOBAL_CLOCK_EN,
  output logic              USB_PLL_POWERDOWN,
  output logic              MAIN_PLL_POWERDOWN,
  output logic              REFCLK_GATE,
  output logic              USB_PHY_RESET,
  output logic              USB_PHY_SUSPEND_N,
  output logic              BASEBAND_WARM_RESET,
  output logic              BASEBAND_COLD_RESET,
  output logic              CLOCKGEN_COLD_RESET,
  output logic              RADIO_WARM_RESET,
  output logic              RADIO_COLD_RESET,
  output logic              RF_FRONT_RESET,
  output logic              BUS_RESET,
  output logic              CPU_CORE_RESET,
  output logic              HOST_DMA_RESET,
  output logic              WIRELESS_RESET,
  output logic              PLL_OUTPUT_INVERT,
  output logic              VCO_REGULATOR_LEVEL,
  output logic [2:0]        VC_CLAMP_CURRENT,
  output logic [2:0]        PUMP_CURRENT_SELECT,
  output logic [7:0]        PLL_LOOP_FILTER,
  output logic [1:0]        ANALOG_PROBE_SELECT,
  output logic [9:0]        PLL_FEEDBACK_DIV,
  output logic [3:0]        PLL_REFERENCE_RATIO
);

  // ------------------------------
  // helpers
  // ------------------------------
  function automatic word_t merge_write(input word_t old_val,
                                        input word_t wdata,
                                        input logic [3:0] strb,
                                        input word_t mask);
    word_t res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    // reserved bits never store a value
    merge_write = res & mask;
  endfunction

  function automatic logic is_mapped(input logic [19:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr[19:2] == `RCP_CLOCK_CONFIG_ADDR >> 2) begin
      hit = 1'b1;
    end else if (addr[19:2] == `RCP_CONTROL_ADDR >> 2) begin
      hit = 1'b1;
    end else if (addr[19:2] == `RCP_PLL_ADDR >> 2) begin
      hit = 1'b1;
    end else if (addr[19:2] == `RCP_STATUS_WORD_ADDR >> 2) begin
      hit = 1'b1;
    end else if (addr[19:2] == `RCP_REVISION_ADDR >> 2) begin
      hit = 1'b1;
    end
    is_mapped = hit;
  endfunction

  // ------------------------------
  // state
  // ------------------------------
  word_t       clock_config;
  word_t       reset_powerdown_control;
  word_t       usb_pll_parameters;
  word_t       reset_status_word;
  logic        aw_held;
  logic        w_held;
  logic [19:0] wr_addr;
  word_t       wr_data;
  logic [3:0]  wr_strb;
  logic [2:0]  sync_a;
  logic [2:0]  sync_b;

  word_t       next_clock_config;
  word_t       next_reset_powerdown_control;
  word_t       next_usb_pll_parameters;
  word_t       next_reset_status_word;
  logic        next_aw_held;
  logic        next_w_held;
  logic [19:0] next_wr_addr;
  word_t       next_wr_data;
  logic [3:0]  next_wr_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  word_t       next_rdata;
  logic [1:0]  next_rresp;
  logic        do_write;
  word_t       revision_word;

  assign revision_word = {24'h000000, REV_MAJOR, REV_MINOR};

  // ------------------------------
  // bus slave and register file
  // ------------------------------
  always_comb begin
    next_aw_held                 = aw_held;
    next_w_held                  = w_held;
    next_wr_addr                 = wr_addr;
    next_wr_data                 = wr_data;
    next_wr_strb                 = wr_strb;
    next_bvalid                  = S_AXI_BVALID;
    next_bresp                   = S_AXI_BRESP;
    next_rvalid                  = S_AXI_RVALID;
    next_rdata                   = S_AXI_RDATA;
    next_rresp                   = S_AXI_RRESP;
    next_clock_config            = clock_config;
    next_reset_powerdown_control = reset_powerdown_control;
    next_usb_pll_parameters      = usb_pll_parameters;
    next_reset_status_word       = reset_status_word;
    do_write                     = aw_held && w_held && !S_AXI_BVALID;

    if (S_AXI_BVALID && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_held = 1'b1;
      next_wr_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_held  = 1'b1;
      next_wr_data = S_AXI_WDATA;
      next_wr_strb = S_AXI_WSTRB;
    end

    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      if (wr_addr[19:2] == `RCP_CLOCK_CONFIG_ADDR >> 2) begin
        next_clock_config = merge_write(clock_config, wr_data,
                                        wr_strb, `RCP_CC_MASK);
      end else if (wr_addr[19:2] == `RCP_CONTROL_ADDR >> 2) begin
        next_reset_powerdown_control =
          merge_write(reset_powerdown_control, wr_data,
                      wr_strb, `RCP_RC_MASK);
      end else if (wr_addr[19:2] == `RCP_PLL_ADDR >> 2) begin
        next_usb_pll_parameters = merge_write(usb_pll_parameters,
                                              wr_data, wr_strb,
                                              `RCP_PLL_MASK);
      end else if (wr_addr[19:2] == `RCP_STATUS_WORD_ADDR >> 2) begin
        next_reset_status_word = merge_write(reset_status_word,
                                             wr_data, wr_strb,
                                             `RCP_STATUS_MASK);
      end
    end

    if (S_AXI_RVALID && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      if (S_AXI_ARADDR[19:2] == `RCP_CLOCK_CONFIG_ADDR >> 2) begin
        next_rdata = clock_config;
      end else if (S_AXI_ARADDR[19:2] == `RCP_CONTROL_ADDR >> 2) begin
        next_rdata = reset_powerdown_control;
      end else if (S_AXI_ARADDR[19:2] == `RCP_PLL_ADDR >> 2) begin
        next_rdata = usb_pll_parameters;
      end else if (S_AXI_ARADDR[19:2] == `RCP_STATUS_WORD_ADDR >> 2) begin
        next_rdata = reset_status_word;
      end else if (S_AXI_ARADDR[19:2] == `RCP_REVISION_ADDR >> 2) begin
        next_rdata = revision_word;
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      aw_held                 <= 1'b0;
      w_held                  <= 1'b0;
      wr_addr                 <= 20'h00000;
      wr_data                 <= 32'h00000000;
      wr_strb                 <= 4'h0;
      S_AXI_AWREADY           <= 1'b0;
      S_AXI_WREADY            <= 1'b0;
      S_AXI_BVALID            <= 1'b0;
      S_AXI_BRESP             <= 2'h0;
      S_AXI_ARREADY           <= 1'b0;
      S_AXI_RVALID            <= 1'b0;
      S_AXI_RDATA             <= 32'h00000000;
      S_AXI_RRESP             <= 2'h0;
      clock_config            <= `RCP_CC_RESET;
      reset_powerdown_control <= `RCP_RC_RESET;
      usb_pll_parameters      <= `RCP_PLL_RESET;
      reset_status_word       <= `RCP_STATUS_RESET;
    end else begin
      aw_held                 <= next_aw_held;
      w_held                  <= next_w_held;
      wr_addr                 <= next_wr_addr;
      wr_data                 <= next_wr_data;
      wr_strb                 <= next_wr_strb;
      // one write in flight: ready drops while held or answering
      S_AXI_AWREADY           <= !next_aw_held && !next_bvalid;
      S_AXI_WREADY            <= !next_w_held && !next_bvalid;
      S_AXI_BVALID            <= next_bvalid;
      S_AXI_BRESP             <= next_bresp;
      S_AXI_ARREADY           <= !next_rvalid;
      S_AXI_RVALID            <= next_rvalid;
      S_AXI_RDATA             <= next_rdata;
      S_AXI_RRESP             <= next_rresp;
      clock_config            <= next_clock_config;
      reset_powerdown_control <= next_reset_powerdown_control;
      usb_pll_parameters      <= next_usb_pll_parameters;
      reset_status_word       <= next_reset_status_word;
    end
  end

  // ------------------------------
  // usb side inputs come from another clock: two-flop synchronisers
  // ------------------------------
  logic [2:0] next_sync_a;
  logic [2:0] next_sync_b;

  always_comb begin
    next_sync_a = {USB_CTRL_PHY_SUSPEND_N, USB_CTRL_PHY_RESET,
                   USB_SUSPEND_REQ};
    next_sync_b = sync_a;
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      sync_a <= 3'h4;
      sync_b <= 3'h4;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
    end
  end

  // ------------------------------
  // control outputs, taken from the next register value so that a write
  // reaches the pins on the same edge that stores it
  // ------------------------------
  word_t      cc;
  word_t      rc;
  logic       suspend_s;
  logic       mac_pass;
  logic       next_bus_gate;
  logic       next_usb_gate;
  logic [2:0] next_cpu_sel;
  logic [1:0] next_bus_div;
  logic       next_glbl_en;
  logic       next_usb_pll_pd;
  logic       next_main_pll_pd;
  logic       next_refclk_gate;
  logic       next_phy_reset;
  logic       next_phy_susp_n;
  logic [3:0] next_bb_radio;
  logic       next_cg_cold;
  logic       next_rf_reset;
  logic [3:0] next_block_reset;

  always_comb begin
    cc        = next_clock_config;
    rc        = next_reset_powerdown_control;
    suspend_s = sync_b[0];
    mac_pass  = rc[`RCP_RC_MAC_PASS];
    next_bus_gate = cc[`RCP_CC_BUS_GATE];
    next_usb_gate = cc[`RCP_CC_USB_GATE];
    next_cpu_sel  = cc[`RCP_CC_CPU_SEL_HI:`RCP_CC_CPU_SEL_LO];
    // the fastest and the oscillator settings cannot be divided down
    if (next_cpu_sel == `RCP_CPU_SEL_117 ||
        next_cpu_sel == `RCP_CPU_SEL_OSC) begin
      next_bus_div = `RCP_BUS_DIV_ONE;
    end else begin
      next_bus_div = cc[`RCP_CC_BUS_DIV_HI:`RCP_CC_BUS_DIV_LO];
    end
    next_glbl_en = rc[`RCP_RC_GLBL_CLK_SRC] ?
                   MAC_GLOBAL_CLK_EN : 1'b1;
    next_usb_pll_pd  = rc[`RCP_RC_USB_PLL_PD] | suspend_s;
    next_main_pll_pd = rc[`RCP_RC_MAIN_PLL_PD] | suspend_s;
    next_refclk_gate = rc[`RCP_RC_REFCLK_GATE] | suspend_s;
    next_phy_reset = rc[`RCP_RC_PHY_RST_SEL] ?
                     sync_b[1] : rc[`RCP_RC_PHY_RST_SW];
    next_phy_susp_n = rc[`RCP_RC_PHY_SUSP_FORCE] ?
                      1'b0 : sync_b[2];
    // software request or, when passed, the mac's own request
    next_bb_radio[0] = rc[`RCP_RC_BB_WARM] |
                       (mac_pass & MAC_BB_WARM_RESET);
    next_bb_radio[1] = rc[`RCP_RC_BB_COLD] |
                       (mac_pass & MAC_BB_COLD_RESET);
    next_bb_radio[2] = rc[`RCP_RC_RADIO_WARM] |
                       (mac_pass & MAC_RADIO_WARM_RESET);
    next_bb_radio[3] = rc[`RCP_RC_RADIO_COLD] |
                       (mac_pass & MAC_RADIO_COLD_RESET);
    next_cg_cold  = rc[`RCP_RC_CG_COLD];
    next_rf_reset = rc[`RCP_RC_RF_RESET];
    next_block_reset[0] = rc[`RCP_RC_GLOBAL] & rc[`RCP_RC_BUS_MSK];
    next_block_reset[1] = rc[`RCP_RC_GLOBAL] & rc[`RCP_RC_CPU_MSK];
    next_block_reset[2] = rc[`RCP_RC_GLOBAL] & rc[`RCP_RC_DMA_MSK];
    next_block_reset[3] = rc[`RCP_RC_GLOBAL] & rc[`RCP_RC_WLAN_MSK];
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      BUS_CLK_GATE          <= 1'b0;
      USB_CTRL_CLOCK_GATE   <= 1'b0;
      CPU_CLK_SEL           <= 3'h0;
      BUS_CLK_DIV           <= 2'h0;
      RADIO_GLOBAL_CLOCK_EN <= 1'b1;
      USB_PLL_POWERDOWN     <= 1'b0;
      MAIN_PLL_POWERDOWN    <= 1'b0;
      REFCLK_GATE           <= 1'b0;
      USB_PHY_RESET         <= 1'b0;
      USB_PHY_SUSPEND_N     <= 1'b1;
      BASEBAND_WARM_RESET   <= 1'b0;
      BASEBAND_COLD_RESET   <= 1'b0;
      RADIO_WARM_RESET      <= 1'b0;
      RADIO_COLD_RESET      <= 1'b0;
      CLOCKGEN_COLD_RESET   <= 1'b0;
      RF_FRONT_RESET        <= 1'b1;
      BUS_RESET             <= 1'b0;
      CPU_CORE_RESET        <= 1'b0;
      HOST_DMA_RESET        <= 1'b0;
      WIRELESS_RESET        <= 1'b0;
    end else begin
      BUS_CLK_GATE          <= next_bus_gate;
      USB_CTRL_CLOCK_GATE   <= next_usb_gate;
      CPU_CLK_SEL           <= next_cpu_sel;
      BUS_CLK_DIV           <= next_bus_div;
      RADIO_GLOBAL_CLOCK_EN <= next_glbl_en;
      USB_PLL_POWERDOWN     <= next_usb_pll_pd;
      MAIN_PLL_POWERDOWN    <= next_main_pll_pd;
      REFCLK_GATE           <= next_refclk_gate;
      USB_PHY_RESET         <= next_phy_reset;
      USB_PHY_SUSPEND_N     <= next_phy_susp_n;
      BASEBAND_WARM_RESET   <= next_bb_radio[0];
      BASEBAND_COLD_RESET   <= next_bb_radio[1];
      RADIO_WARM_RESET      <= next_bb_radio[2];
      RADIO_COLD_RESET      <= next_bb_radio[3];
      CLOCKGEN_COLD_RESET   <= next_cg_cold;
      RF_FRONT_RESET        <= next_rf_reset;
      BUS_RESET             <= next_block_reset[0];
      CPU_CORE_RESET        <= next_block_reset[1];
      HOST_DMA_RESET        <= next_block_reset[2];
      WIRELESS_RESET        <= next_block_reset[3];
    end
  end

  // ------------------------------
  // pll settings are static: driven straight from the register flops
  // ------------------------------
  assign PLL_OUTPUT_INVERT   = usb_pll_parameters[31];
  assign VCO_REGULATOR_LEVEL = usb_pll_parameters[30];
  assign VC_CLAMP_CURRENT    = usb_pll_parameters[29:27];
  assign PUMP_CURRENT_SELECT = usb_pll_parameters[26:24];
  assign PLL_LOOP_FILTER     = usb_pll_parameters[23:16];
  assign ANALOG_PROBE_SELECT = usb_pll_parameters[15:14];
  assign PLL_FEEDBACK_DIV    = usb_pll_parameters[13:4];
  assign PLL_REFERENCE_RATIO = usb_pll_parameters[3:0];

endmodule

//--- rcp_sva.sv
// assertion checker for the reset, clock and power-down control block
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// checker
// ----------------------------------------------------------------------
module rcp_sva (
  input wire logic       CLK,
  input wire logic       NRST,
  input wire logic       S_AXI_AWVALID,
  input wire logic       S_AXI_AWREADY,
  input wire logic       S_AXI_WVALID,
  input wire logic       S_AXI_WREADY,
  input wire logic       S_AXI_BVALID,
  input wire logic       S_AXI_ARVALID,
  input wire logic       S_AXI_ARREADY,
  input wire logic       S_AXI_RVALID,
  input wire logic       USB_SUSPEND_REQ,
  input wire logic       USB_CTRL_PHY_SUSPEND_N,
  input wire logic       MAC_GLOBAL_CLK_EN,
  input wire logic [2:0] CPU_CLK_SEL,
  input wire logic [1:0] BUS_CLK_DIV,
  input wire logic       RADIO_GLOBAL_CLOCK_EN,
  input wire logic       USB_PLL_POWERDOWN,
  input wire logic       MAIN_PLL_POWERDOWN,
  input wire logic       REFCLK_GATE,
  input wire logic       USB_PHY_SUSPEND_N,
  input wire logic       BUS_RESET,
  input wire logic       RF_FRONT_RESET
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_ratio_force: assert property (CPU_CLK_SEL inside {3'h5, 3'h6}
    |-> BUS_CLK_DIV == 2'h0) else $error("bus ratio not forced to one");
  a_radio_clk_mac: assert property (!RADIO_GLOBAL_CLOCK_EN
    |-> !$past(MAC_GLOBAL_CLK_EN)) else $error("radio clock enable low");
  // two sync flops plus output flop: three samples before the check
  a_suspend_powerdown: assert property (USB_SUSPEND_REQ [*3]
    |=> USB_PLL_POWERDOWN && MAIN_PLL_POWERDOWN && REFCLK_GATE)
    else $error("suspend did not power down");
  a_phy_susp_follow: assert property (!USB_CTRL_PHY_SUSPEND_N [*3]
    |=> !USB_PHY_SUSPEND_N) else $error("phy suspend not passed");
  a_write_latency: assert property (S_AXI_AWVALID && S_AXI_AWREADY
    && S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_AWREADY && !S_AXI_BVALID
    ##1 S_AXI_BVALID) else $error("write response timing");
  a_write_refuse: assert property (S_AXI_BVALID
    |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write not refused");
  a_read_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer timing");
  a_read_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read not refused");
  a_reset_by_write: assert property ($changed(BUS_RESET)
    || $changed(RF_FRONT_RESET) |-> $rose(S_AXI_BVALID))
    else $error("reset output moved without a write");
  c_write: cover property ($rose(S_AXI_BVALID));
  c_read: cover property ($rose(S_AXI_RVALID));
  c_powerdown: cover property ($rose(USB_PLL_POWERDOWN));
  c_bus_reset: cover property ($rose(BUS_RESET));
endmodule

bind reset_clock_power_control rcp_sva rcp_sva_inst (.*);

//--- tb_reset_clock_power_control.sv
// self-checking bench for the reset, clock and power-down control block
`timescale 1ns/100ps
module tb_reset_clock_power_control import rcp_pkg::*; ;
  // ------------------------------
  // signals
  // ------------------------------
  typedef struct packed {
    logic [7:0] o;
    word_t      d;
    word_t      e;
    logic [7:0] i;
  } row_t;
  logic CLK = 1'b0, NRST = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic [19:0] S_AXI_AWADDR = 20'h0, S_AXI_ARADDR = 20'h0;
  logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  word_t S_AXI_WDATA = 32'h0, S_AXI_RDATA, rv;
  logic MAC_GLOBAL_CLK_EN = 1'b0, USB_SUSPEND_REQ = 1'b0;
  logic USB_CTRL_PHY_RESET = 1'b0, USB_CTRL_PHY_SUSPEND_N = 1'b1;
  logic MAC_BB_WARM_RESET = 1'b0, MAC_BB_COLD_RESET = 1'b0;
  logic MAC_RADIO_WARM_RESET = 1'b0, MAC_RADIO_COLD_RESET = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, BUS_CLK_GATE, USB_CTRL_CLOCK_GATE;
  logic RADIO_GLOBAL_CLOCK_EN, USB_PLL_POWERDOWN, MAIN_PLL_POWERDOWN;
  logic REFCLK_GATE, USB_PHY_RESET, USB_PHY_SUSPEND_N, BASEBAND_WARM_RESET;
  logic BASEBAND_COLD_RESET, CLOCKGEN_COLD_RESET, RADIO_WARM_RESET;
  logic RADIO_COLD_RESET, RF_FRONT_RESET, BUS_RESET, CPU_CORE_RESET;
  logic HOST_DMA_RESET, WIRELESS_RESET, PLL_OUTPUT_INVERT;
  logic VCO_REGULATOR_LEVEL;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, BUS_CLK_DIV, ANALOG_PROBE_SELECT, rr;
  logic [2:0] CPU_CLK_SEL, VC_CLAMP_CURRENT, PUMP_CURRENT_SELECT;
  logic [7:0] PLL_LOOP_FILTER;
  logic [9:0] PLL_FEEDBACK_DIV;
  logic [3:0] PLL_REFERENCE_RATIO;
  int errors = 0, cmp_count = 0, cycles = 0;
  row_t q;
  word_t rst_v [4] = '{32'h0, 32'h20, 32'h6e1501e5, 32'h0};
  // offset low byte, write data, read-back, side inputs
  row_t rows [16] = '{
    '{8'h40, 32'h2010, 32'h2010, 8'h10}, '{8'h40, 32'h1011, 32'h1011, 8'h10},
    '{8'h40, 32'h2012, 32'h2012, 8'h10}, '{8'h40, 32'h201d, 32'h201d, 8'h10},
    '{8'h40, 32'h2006, 32'h2006, 8'h10}, '{8'h44, 32'h1e3715, 32'h1e3715, 0},
    '{8'h44, 32'hffffffff, 32'h1e7fff, 8'h10}, '{8'h44, 32'h18ea, 32'h18ea, 255},
    '{8'h44, 32'h401f, 32'h401f, 8'h10}, '{8'h44, 32'h4000, 32'h4000, 8'h9f},
    '{8'h44, 32'h0, 32'h0, 8'hff}, '{8'h44, 32'h2000, 32'h2000, 8'h20},
    '{8'h48, 32'h12345678, 32'h12345678, 8'h10},
    '{8'h4c, 32'ha5a5a5a5, 32'ha5a5a5a5, 8'h10},
    '{8'h90, 32'hffffffff, 32'h10, 8'h10}, '{8'h50, 32'hffffffff, 0, 8'h10}};
  wire word_t pll_o = {PLL_OUTPUT_INVERT, VCO_REGULATOR_LEVEL,
    VC_CLAMP_CURRENT, PUMP_CURRENT_SELECT, PLL_LOOP_FILTER,
    ANALOG_PROBE_SELECT, PLL_FEEDBACK_DIV, PLL_REFERENCE_RATIO};
  wire word_t cc_o = {25'h0, BUS_CLK_GATE, USB_CTRL_CLOCK_GATE, CPU_CLK_SEL,
    BUS_CLK_DIV};
  wire [15:0] rc_o = {RADIO_GLOBAL_CLOCK_EN, USB_PLL_POWERDOWN,
    MAIN_PLL_POWERDOWN, REFCLK_GATE, USB_PHY_RESET, USB_PHY_SUSPEND_N,
    BASEBAND_WARM_RESET, BASEBAND_COLD_RESET, CLOCKGEN_COLD_RESET,
    RADIO_WARM_RESET, RADIO_COLD_RESET, RF_FRONT_RESET, BUS_RESET,
    CPU_CORE_RESET, HOST_DMA_RESET, WIRELESS_RESET};
  reset_clock_power_control reset_clock_power_control_inst (.*);
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk(string n, word_t e, word_t g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] o, word_t d, output logic [1:0] r);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    @(posedge CLK);
    S_AXI_AWADDR <= {12'h500, o};
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    while (a | w) begin
      @(posedge CLK);
      if (S_AXI_AWREADY === 1'b1) a = 1'b0;
      if (S_AXI_WREADY === 1'b1) w = 1'b0;
      S_AXI_AWVALID <= a;
      S_AXI_WVALID <= w;
    end
    do @(posedge CLK); while (S_AXI_BVALID !== 1'b1);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(logic [7:0] o, output word_t d, output logic [1:0] r);
    @(posedge CLK);
    S_AXI_ARADDR <= {12'h500, o};
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do @(posedge CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK); while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task close_out;
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------
  // clock, timeout, sequence
  // ------------------------------
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      close_out;
    end
  end
  initial begin
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      q = rows[k];
      {MAC_GLOBAL_CLK_EN, USB_SUSPEND_REQ, USB_CTRL_PHY_RESET,
        USB_CTRL_PHY_SUSPEND_N, MAC_BB_WARM_RESET, MAC_BB_COLD_RESET,
        MAC_RADIO_WARM_RESET, MAC_RADIO_COLD_RESET} <= q.i;
      // let the two-flop input synchronisers settle first
      repeat (4) @(posedge CLK);
      wr(q.o, q.d, rr);
      chk("bresp", {q.o == 8'h50, 1'b0}, rr);
      rd(q.o, rv, rr);
      chk("rresp", {q.o == 8'h50, 1'b0}, rr);
      chk("rdata", q.e, rv);
      if (q.o == 8'h40) chk("clk", {25'h0, q.d[4:0], q.d[2:0] inside
        {3'h5, 3'h6} ? 2'h0 : q.d[13:12]}, cc_o);
      if (q.o == 8'h44) chk("ctrl", {q.d[20] ? q.i[7] : 1'b1,
        q.d[19:17] | {3{q.i[6]}},
        q.d[13] ? q.i[5] : q.d[12], ~q.d[11] & q.i[4],
        q.d[10] | q.d[14] & q.i[3], q.d[9] | q.d[14] & q.i[2], q.d[8],
        q.d[7] | q.d[14] & q.i[1], q.d[6] | q.d[14] & q.i[0], q.d[5],
        {4{q.d[0]}} & q.d[4:1]}, rc_o);
      if (q.o == 8'h48) chk("pll", q.d, pll_o);
    end
    NRST <= 1'b0;
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    chk("rf_rst", 32'h1, RF_FRONT_RESET);
    chk("pll_rst", 32'h6e1501e5, pll_o);
    for (int k = 0; k < 4; k++) begin
      rd(8'h40 + 8'(4 * k), rv, rr);
      chk("reset", rst_v[k], rv);
    end
    close_out;
  end
endmodule
